// file: core/mbp_defines.svh
`ifndef MBP_DEFINES_SVH
`define MBP_DEFINES_SVH

// Level seen on an undriven pin (pull-up)
`define MBP_FLOAT_LEVEL   8'hff
// Reset values of the port data and direction registers
`define MBP_IO_RESET      8'h00
`define MBP_DIR_RESET     8'h00
// Register select: bit 0 of the latched upper address
`define MBP_REG_SEL_BIT   0
// Chip-select field of the latched upper address
`define MBP_SEL_MSB       7
`define MBP_SEL_LSB       4
`define MBP_SEL_BASE      4'h8
// Host timing, in ref_clk cycles
`define MBP_STROBE_CYC    3

`endif

// file: core/mbp_pkg.sv
package mbp_pkg;

	typedef enum logic [0:0] {
		MBP_C0_WRITE_STROBE = 1'h0,
		MBP_C0_DIRECTION    = 1'h1
	} mbp_c0_mode_t;

	typedef enum logic [1:0] {
		MBP_C1_READ_STROBE = 2'h0,
		MBP_C1_E_CLOCK     = 2'h1,
		MBP_C1_DATA_STROBE = 2'h2,
		MBP_C1_FETCH_READ  = 2'h3
	} mbp_c1_mode_t;

	typedef enum logic [0:0] {
		MBP_C2_GENERIC = 1'h0,
		MBP_C2_FETCH   = 1'h1
	} mbp_c2_mode_t;

	typedef enum logic [2:0] {
		MBP_PA_MCU_IO       = 3'h0,
		MBP_PA_MACROCELL    = 3'h1,
		MBP_PA_LOGIC_IN     = 3'h2,
		MBP_PA_LATCHED_ADDR = 3'h3,
		MBP_PA_ADDR_IN      = 3'h4,
		MBP_PA_DATA_BUS     = 3'h5
	} mbp_pa_func_t;

	typedef enum logic [1:0] {
		MBP_STYLE_SPLIT = 2'h0,
		MBP_STYLE_E     = 2'h1,
		MBP_STYLE_DS    = 2'h2,
		MBP_STYLE_FETCH = 2'h3
	} mbp_bus_style_t;

	typedef enum logic [3:0] {
		MBP_H_IDLE   = 4'h1,
		MBP_H_ADDR   = 4'h2,
		MBP_H_STROBE = 4'h4,
		MBP_H_DONE   = 4'h8
	} mbp_host_state_t;

endpackage

// file: core/mbp_bus_if.sv
`timescale 1ns/1ps
`include "mbp_defines.svh"

interface mbp_bus_if;
	logic       address_strobe;
	logic       ctrl_input_zero;
	logic       ctrl_input_one;
	logic       ctrl_input_two;
	logic [7:0] upper_ad_host_out;
	logic       upper_ad_host_oe;
	logic [7:0] upper_ad_dev_out;
	logic       upper_ad_dev_oe;
	logic [7:0] upper_address_data_port;
	logic [7:0] port_a_host_out;
	logic [7:0] port_a_host_oe;
	logic [7:0] port_a_dev_out;
	logic [7:0] port_a_dev_oe;
	logic [7:0] port_a_pins;

	// Wire levels; device wins a clash, otherwise pull-up
	assign upper_address_data_port =
		upper_ad_dev_oe ? upper_ad_dev_out :
		upper_ad_host_oe ? upper_ad_host_out : `MBP_FLOAT_LEVEL;
	assign port_a_pins = (port_a_dev_oe & port_a_dev_out) |
		(~port_a_dev_oe & port_a_host_oe & port_a_host_out) |
		(~port_a_dev_oe & ~port_a_host_oe & `MBP_FLOAT_LEVEL);

	modport device (
		input  address_strobe, ctrl_input_zero, ctrl_input_one,
		input  ctrl_input_two, upper_address_data_port, port_a_pins,
		output upper_ad_dev_out, upper_ad_dev_oe,
		output port_a_dev_out, port_a_dev_oe
	);

	modport host (
		input  upper_address_data_port, port_a_pins,
		output address_strobe, ctrl_input_zero, ctrl_input_one,
		output ctrl_input_two, upper_ad_host_out, upper_ad_host_oe,
		output port_a_host_out, port_a_host_oe
	);
endinterface

// file: core/mbp_port_pin.sv
`timescale 1ns/1ps

module mbp_port_pin (
	// Clock and reset
	input  logic ref_clk,
	input  logic reset_n,
	// Pin request
	input  logic drive_en,
	input  logic value,
	input  logic open_drain,
	// Pin driver
	output logic pin_out,
	output logic pin_oe
);
	logic out_d;
	logic oe_d;

	always_comb begin
		out_d = value;
		oe_d  = drive_en;
		// Open drain only ever pulls low
		if (open_drain) begin
			out_d = 1'b0;
			oe_d  = drive_en & ~value;
		end
		if (!reset_n) begin
			out_d = 1'b0;
			oe_d  = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		pin_out <= out_d;
		pin_oe  <= oe_d;
	end
endmodule

// file: core/mbp_device.sv
`timescale 1ns/1ps
`include "mbp_defines.svh"

// Function
// RL1: Address strobe high latches upper port address
// RL2: Drive data only on read while selected
// RL3: Latched upper address feeds logic terms
// RL4: Burst host puts high address/data on port
// RL5: Control zero as active-low write strobe
// RL6: Control zero as direction, high means read
// RL7: Control one as read strobe or E clock
// RL8: Control one as active-low data strobe
// RL9: Host fetch strobe wired to control one
// RL10: Control two fetch strobe or generic input
// RL11: All control inputs feed logic terms
// RL12: Reset clears ports, macrocells, some configuration
// RL13: Host holds reset low during power-up
// RL14: Port pin: host I/O, macrocell, logic input
// RL15: Port pin may output latched address bits
// RL16: Port pins may take address inputs
// RL17: Port pins may form the data bus
// RL18: Low four pins push-pull, optional fast slew
// RL19: High four pins push-pull or open drain
// RL20: Modes come from configuration loaded beforehand
module mbp_device
	import mbp_pkg::*;
#(
	parameter logic [3:0] SEL_BASE = `MBP_SEL_BASE
) (
	// Clock and reset
	input  logic                ref_clk,
	input  logic                reset_n,
	// Host bus
	mbp_bus_if.device           bus,
	// Configuration, loaded while reset_n is low
	input  mbp_c0_mode_t        cfg_c0_mode,
	input  mbp_c1_mode_t        cfg_c1_mode,
	input  mbp_c2_mode_t        cfg_c2_mode,
	input  mbp_pa_func_t [7:0]  cfg_pa_func,
	input  logic [3:0]          cfg_pa_open_drain,
	input  logic [3:0]          cfg_pa_fast_slew,
	// Macrocell outputs shared onto port A
	input  logic [7:0]          shared_macrocell_outputs,
	// Terms toward the logic arrays
	output logic [11:0]         logic_addr,
	output logic [2:0]          logic_ctrl,
	output logic [7:0]          logic_port_a,
	output logic                bus_read,
	output logic                bus_write,
	output logic                fetch_active,
	output logic                block_selected,
	output logic [3:0]          pa_fast_slew
);
	// Configuration group
	mbp_c0_mode_t       c0_mode_q, c0_mode_d;
	mbp_c1_mode_t       c1_mode_q, c1_mode_d;
	mbp_c2_mode_t       c2_mode_q, c2_mode_d;
	mbp_pa_func_t [7:0] pa_func_q, pa_func_d;
	logic [3:0]         pa_od_q, pa_od_d;
	logic [3:0]         slew_q, slew_d;

	always_comb begin
		c0_mode_d = c0_mode_q;
		c1_mode_d = c1_mode_q;
		c2_mode_d = c2_mode_q;
		pa_func_d = pa_func_q;
		pa_od_d   = pa_od_q;
		slew_d    = slew_q;
		// Frozen once the bus runs; a mode swap mid-cycle is unsafe
		if (!reset_n) begin // [RL20]
			c0_mode_d = cfg_c0_mode;
			c1_mode_d = cfg_c1_mode;
			c2_mode_d = cfg_c2_mode;
			pa_func_d = cfg_pa_func;
			pa_od_d   = cfg_pa_open_drain;
			slew_d    = cfg_pa_fast_slew;
		end
	end

	always_ff @(posedge ref_clk) begin
		c0_mode_q <= c0_mode_d;
		c1_mode_q <= c1_mode_d;
		c2_mode_q <= c2_mode_d;
		pa_func_q <= pa_func_d;
		pa_od_q   <= pa_od_d;
		slew_q    <= slew_d;
	end

	// Strobe decode
	logic rd_now;
	logic wr_now;
	logic fetch_now;
	logic qual_now;
	logic dir_style;

	always_comb begin
		rd_now    = 1'b0;
		wr_now    = 1'b0;
		fetch_now = 1'b0;
		qual_now  = 1'b1;
		dir_style = 1'b0;
		unique case (c1_mode_q)
			MBP_C1_READ_STROBE: rd_now = !bus.ctrl_input_one; // [RL7]
			MBP_C1_FETCH_READ:  rd_now = !bus.ctrl_input_one; // [RL9]
			MBP_C1_E_CLOCK: begin
				qual_now  = bus.ctrl_input_one; // [RL7]
				dir_style = 1'b1;
			end
			MBP_C1_DATA_STROBE: begin
				qual_now  = !bus.ctrl_input_one; // [RL8]
				dir_style = 1'b1;
			end
		endcase
		if (c0_mode_q == MBP_C0_WRITE_STROBE) begin
			wr_now = !bus.ctrl_input_zero; // [RL5]
		end else if (dir_style) begin
			rd_now = bus.ctrl_input_zero & qual_now; // [RL6]
			wr_now = !bus.ctrl_input_zero & qual_now; // [RL6]
		end
		if (c2_mode_q == MBP_C2_FETCH) begin
			fetch_now = !bus.ctrl_input_two; // [RL10]
			rd_now    = rd_now | fetch_now;
		end
	end

	// Per-pin port A logic
	logic [7:0] upper_q, upper_d;
	logic [3:0] pa_addr_q, pa_addr_d;
	logic [7:0] io_q, io_d;
	logic [7:0] dir_q, dir_d;
	logic [7:0] wdata_q, wdata_d;
	logic       wr_prev_q, wr_prev_d;
	logic [7:0] wdata_now;
	logic [7:0] io_rd;
	logic [7:0] rdata;
	logic [7:0] pin_en;
	logic [7:0] pin_val;
	logic [7:0] data_pin;
	logic [3:0] addr_in_pin;
	logic       sel_now;

	assign sel_now = upper_q[`MBP_SEL_MSB:`MBP_SEL_LSB] == SEL_BASE;
	assign rdata   = upper_q[`MBP_REG_SEL_BIT] ? dir_q : io_rd;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			logic od;
			assign data_pin[i] = pa_func_q[i] == MBP_PA_DATA_BUS;
			assign wdata_now[i] = data_pin[i] ? bus.port_a_pins[i]
				: bus.upper_address_data_port[i]; // [RL17]
			// Output bits read back the latch, input bits the pin
			assign io_rd[i] = (pa_func_q[i] == MBP_PA_MCU_IO && dir_q[i])
				? io_q[i] : bus.port_a_pins[i];
			always_comb begin
				pin_en[i]  = 1'b0;
				pin_val[i] = 1'b0;
				unique case (pa_func_q[i])
					MBP_PA_MCU_IO: begin // [RL14]
						pin_en[i]  = dir_q[i];
						pin_val[i] = io_q[i];
					end
					MBP_PA_MACROCELL: begin // [RL14]
						pin_en[i]  = 1'b1;
						pin_val[i] = shared_macrocell_outputs[i];
					end
					MBP_PA_LATCHED_ADDR: begin // [RL15]
						pin_en[i]  = 1'b1;
						pin_val[i] = logic_addr[i];
					end
					MBP_PA_DATA_BUS: begin
						pin_en[i]  = rd_now & sel_now; // [RL2]
						pin_val[i] = rdata[i];
					end
					MBP_PA_LOGIC_IN, MBP_PA_ADDR_IN: begin
						pin_en[i]  = 1'b0;
						pin_val[i] = 1'b0;
					end
					default: begin
						pin_en[i]  = 1'b0;
						pin_val[i] = 1'b0;
					end
				endcase
			end
			if (i >= 4) begin : g_high
				assign od = pa_od_q[i-4]; // [RL19]
			end else begin : g_low
				assign od = 1'b0; // [RL18]
			end
			if (i < 4) begin : g_addr
				assign addr_in_pin[i] = pa_func_q[i] == MBP_PA_ADDR_IN
					&& bus.port_a_pins[i]; // [RL16]
			end
			mbp_port_pin u_pin (
				.ref_clk    (ref_clk),
				.reset_n    (reset_n),
				.drive_en   (pin_en[i]),
				.value      (pin_val[i]),
				.open_drain (od),
				.pin_out    (bus.port_a_dev_out[i]),
				.pin_oe     (bus.port_a_dev_oe[i])
			);
		end
	endgenerate

	// Bus group
	logic [7:0]  up_out_d;
	logic        up_oe_d;
	logic [11:0] laddr_d;
	logic [2:0]  lctrl_d;
	logic [7:0]  lport_d;

	always_comb begin
		upper_d   = upper_q;
		pa_addr_d = pa_addr_q;
		io_d      = io_q;
		dir_d     = dir_q;
		wdata_d   = wdata_q;
		wr_prev_d = wr_now;
		if (bus.address_strobe) begin // [RL1]
			upper_d   = bus.upper_address_data_port;
			pa_addr_d = addr_in_pin;
		end
		if (wr_now) begin
			wdata_d = wdata_now;
		end
		// Commit at the trailing edge, where write data is settled
		if (wr_prev_q && !wr_now && sel_now) begin
			if (upper_q[`MBP_REG_SEL_BIT]) begin
				dir_d = wdata_q;
			end else begin
				io_d = wdata_q;
			end
		end
		// Upper port stays quiet when port A carries the data
		up_oe_d  = rd_now & sel_now & ~|data_pin; // [RL2]
		up_out_d = rdata;
		laddr_d  = {upper_q, pa_addr_q}; // [RL3]
		lctrl_d  = {bus.ctrl_input_two, bus.ctrl_input_one,
			bus.ctrl_input_zero}; // [RL11]
		lport_d  = bus.port_a_pins; // [RL14]
		if (!reset_n) begin // [RL12]
			upper_d   = 8'h00;
			pa_addr_d = 4'h0;
			io_d      = `MBP_IO_RESET;
			dir_d     = `MBP_DIR_RESET;
			wdata_d   = 8'h00;
			wr_prev_d = 1'b0;
			up_oe_d   = 1'b0;
			up_out_d  = 8'h00;
			laddr_d   = 12'h000;
			lctrl_d   = 3'h0;
			lport_d   = 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		upper_q             <= upper_d;
		pa_addr_q           <= pa_addr_d;
		io_q                <= io_d;
		dir_q               <= dir_d;
		wdata_q             <= wdata_d;
		wr_prev_q           <= wr_prev_d;
		bus.upper_ad_dev_oe  <= up_oe_d;
		bus.upper_ad_dev_out <= up_out_d;
		logic_addr          <= laddr_d;
		logic_ctrl          <= lctrl_d;
		logic_port_a        <= lport_d;
		bus_read            <= reset_n & rd_now;
		bus_write           <= reset_n & wr_now;
		fetch_active        <= reset_n & fetch_now;
		block_selected      <= reset_n & sel_now;
		pa_fast_slew        <= reset_n ? slew_q : 4'h0; // [RL18]
	end
endmodule

// file: core/mbp_host.sv
`timescale 1ns/1ps
`include "mbp_defines.svh"

module mbp_host
	import mbp_pkg::*;
#(
	parameter int STROBE_CYC = `MBP_STROBE_CYC
) (
	// Clock and reset
	input  logic           ref_clk,
	input  logic           reset_n,
	// Device bus
	mbp_bus_if.host        bus,
	// Bus style
	input  mbp_bus_style_t style,
	input  logic           data_on_port_a,
	input  logic           addr_on_port_a,
	input  logic           generic_level,
	// Request
	input  logic           req_valid,
	input  logic           req_write,
	input  logic           req_fetch,
	input  logic [11:0]    req_addr,
	input  logic [7:0]     req_wdata,
	// Answer
	output logic           req_ready,
	output logic           rsp_valid,
	output logic [7:0]     rsp_rdata
);
	mbp_host_state_t state_q, state_d;
	logic [7:0]  cnt_q, cnt_d;
	logic        write_q, write_d;
	logic        fetch_q, fetch_d;
	logic [11:0] addr_q, addr_d;
	logic [7:0]  wdata_q, wdata_d;
	logic        as_d, c0_d, c1_d, c2_d, up_oe_d, ready_d, rsp_d;
	logic [7:0]  up_out_d, pa_out_d, pa_oe_d, rdata_d;
	logic        strobe;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		write_d = write_q;
		fetch_d = fetch_q;
		addr_d  = addr_q;
		wdata_d = wdata_q;
		rdata_d = rsp_rdata;
		rsp_d   = 1'b0;
		unique case (state_q)
			MBP_H_IDLE: if (req_valid) begin
				state_d = MBP_H_ADDR;
				write_d = req_write;
				fetch_d = req_fetch & ~req_write;
				addr_d  = req_addr;
				wdata_d = req_wdata;
			end
			MBP_H_ADDR: begin
				state_d = MBP_H_STROBE;
				cnt_d   = 8'(STROBE_CYC - 1);
			end
			MBP_H_STROBE: if (cnt_q == 8'h00) begin
				state_d = MBP_H_DONE;
				rsp_d   = 1'b1;
				if (!write_q) begin
					rdata_d = data_on_port_a ? bus.port_a_pins
						: bus.upper_address_data_port;
				end
			end else begin
				cnt_d = cnt_q - 8'h01;
			end
			MBP_H_DONE: state_d = MBP_H_IDLE;
			default: state_d = MBP_H_IDLE;
		endcase
		if (!reset_n) begin
			state_d = MBP_H_IDLE;
			cnt_d   = 8'h00;
			write_d = 1'b0;
			fetch_d = 1'b0;
			addr_d  = 12'h000;
			wdata_d = 8'h00;
			rdata_d = 8'h00;
			rsp_d   = 1'b0;
		end
		strobe   = state_d == MBP_H_STROBE;
		ready_d  = state_d == MBP_H_IDLE;
		as_d     = state_d == MBP_H_ADDR;
		// High address bits, or high data bits in burst style
		up_out_d = as_d ? addr_d[11:4] : wdata_d; // [RL4]
		up_oe_d  = as_d | (strobe & write_d & ~data_on_port_a);
		pa_out_d = as_d ? {4'h0, addr_d[3:0]} : wdata_d;
		pa_oe_d  = 8'h00;
		if (as_d && addr_on_port_a) begin
			pa_oe_d = 8'h0f;
		end else if (strobe && write_d && data_on_port_a) begin
			pa_oe_d = 8'hff;
		end
		c0_d = ~(strobe & write_d);
		c1_d = ~(strobe & ~write_d & ~fetch_d);
		c2_d = fetch_d ? ~strobe : generic_level;
		unique case (style)
			MBP_STYLE_SPLIT: ;
			MBP_STYLE_E: begin
				c0_d = ~write_d;
				c1_d = strobe;
			end
			MBP_STYLE_DS: begin
				c0_d = ~write_d;
				c1_d = ~strobe;
			end
			MBP_STYLE_FETCH: begin
				c1_d = ~(strobe & ~write_d); // [RL9]
				c2_d = generic_level;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		state_q               <= state_d;
		cnt_q                 <= cnt_d;
		write_q               <= write_d;
		fetch_q               <= fetch_d;
		addr_q                <= addr_d;
		wdata_q               <= wdata_d;
		rsp_rdata             <= rdata_d;
		rsp_valid             <= rsp_d;
		req_ready             <= ready_d;
		bus.address_strobe    <= as_d;
		bus.ctrl_input_zero   <= c0_d;
		bus.ctrl_input_one    <= c1_d;
		bus.ctrl_input_two    <= c2_d;
		bus.upper_ad_host_out <= up_out_d;
		bus.upper_ad_host_oe  <= up_oe_d;
		bus.port_a_host_out   <= pa_out_d;
		bus.port_a_host_oe    <= pa_oe_d;
	end
endmodule

// file: dv/mbp_chk.sv
`timescale 1ns/1ps

module mbp_chk (
	// Clock and reset
	input  logic       ref_clk,
	input  logic       reset_n,
	// Bus signals
	input  logic       address_strobe,
	input  logic       ctrl_input_zero,
	input  logic       upper_ad_host_oe,
	input  logic       upper_ad_dev_oe,
	input  logic [7:0] port_a_dev_oe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_as_host_addr: assert property (
		address_strobe |-> upper_ad_host_oe)
		else $error("address strobe without host address");
	a_as_spacing: assert property (
		$rose(address_strobe) |=> !address_strobe [*6])
		else $error("address strobes too close");
	a_as_port_free: assert property (
		address_strobe |-> !upper_ad_dev_oe)
		else $error("device drives during address phase");
	a_oe_no_clash: assert property (
		upper_ad_dev_oe |-> !upper_ad_host_oe)
		else $error("both ends drive upper port");
	a_oe_after_addr: assert property (
		$rose(upper_ad_dev_oe) |-> $past(address_strobe, 2))
		else $error("device drive not tied to a read");
	a_oe_read_span: assert property (
		$rose(upper_ad_dev_oe) |=>
		upper_ad_dev_oe [*2] ##1 !upper_ad_dev_oe)
		else $error("device drive span wrong");
	a_reset_no_drive: assert property (
		$rose(reset_n) |-> !upper_ad_dev_oe && port_a_dev_oe == 8'h00)
		else $error("device drives out of reset");
	a_reset_host_idle: assert property (
		$rose(reset_n) |-> !address_strobe && !upper_ad_host_oe)
		else $error("host busy out of reset");

	// Main scenarios reached
	c_read_drive: cover property ($rose(upper_ad_dev_oe));
	c_write: cover property ($fell(ctrl_input_zero));
	c_port_drive: cover property (port_a_dev_oe != 8'h00);
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
`include "mbp_defines.svh"

module testbench
	import mbp_pkg::*;
;
	logic               ref_clk;
	logic               reset_n;
	mbp_c0_mode_t       cfg_c0_mode;
	mbp_c1_mode_t       cfg_c1_mode;
	mbp_c2_mode_t       cfg_c2_mode;
	mbp_pa_func_t [7:0] cfg_pa_func;
	logic [3:0]         cfg_pa_open_drain;
	logic [3:0]         cfg_pa_fast_slew;
	logic [7:0]         shared_macrocell_outputs;
	logic [11:0]        logic_addr;
	logic [2:0]         logic_ctrl;
	logic [7:0]         logic_port_a;
	logic [3:0]         pa_fast_slew;
	logic               bus_read;
	logic               bus_write;
	logic               fetch_active;
	logic               block_selected;
	mbp_bus_style_t     style;
	logic               data_on_port_a;
	logic               addr_on_port_a;
	logic               generic_level;
	logic               req_valid;
	logic               req_write;
	logic               req_fetch;
	logic [11:0]        req_addr;
	logic [7:0]         req_wdata;
	logic               req_ready;
	logic               rsp_valid;
	logic [7:0]         rsp_rdata;
	logic [7:0]         rd;
	int                 error_cnt;
	int                 checks_done;

	mbp_bus_if bus ();

	mbp_device u_mbp_device (
		.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus.device),
		.cfg_c0_mode(cfg_c0_mode), .cfg_c1_mode(cfg_c1_mode),
		.cfg_c2_mode(cfg_c2_mode), .cfg_pa_func(cfg_pa_func),
		.cfg_pa_open_drain(cfg_pa_open_drain),
		.cfg_pa_fast_slew(cfg_pa_fast_slew),
		.shared_macrocell_outputs(shared_macrocell_outputs),
		.logic_addr(logic_addr), .logic_ctrl(logic_ctrl),
		.logic_port_a(logic_port_a), .bus_read(bus_read),
		.bus_write(bus_write), .fetch_active(fetch_active),
		.block_selected(block_selected), .pa_fast_slew(pa_fast_slew)
	);

	mbp_host u_mbp_host (
		.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus.host),
		.style(style), .data_on_port_a(data_on_port_a),
		.addr_on_port_a(addr_on_port_a), .generic_level(generic_level),
		.req_valid(req_valid), .req_write(req_write),
		.req_fetch(req_fetch), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata)
	);

	mbp_chk u_mbp_chk (
		.ref_clk(ref_clk), .reset_n(reset_n),
		.address_strobe(bus.address_strobe),
		.ctrl_input_zero(bus.ctrl_input_zero),
		.upper_ad_host_oe(bus.upper_ad_host_oe),
		.upper_ad_dev_oe(bus.upper_ad_dev_oe),
		.port_a_dev_oe(bus.port_a_dev_oe)
	);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t: %s %h/%h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t: %s %h/%h", $time, what, got, exp);
		end
	endtask

	task automatic end_sim();
		if (error_cnt == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Config is only taken while reset is low, so every mode change resets
	task automatic set_cfg(input mbp_bus_style_t s, input mbp_pa_func_t lo,
		input mbp_pa_func_t hi, input logic [3:0] od, input mbp_c2_mode_t c2);
		@(posedge ref_clk);
		style <= s;
		cfg_c0_mode <= (s == MBP_STYLE_E || s == MBP_STYLE_DS) ?
			MBP_C0_DIRECTION : MBP_C0_WRITE_STROBE;
		case (s)
			MBP_STYLE_E: cfg_c1_mode <= MBP_C1_E_CLOCK;
			MBP_STYLE_DS: cfg_c1_mode <= MBP_C1_DATA_STROBE;
			MBP_STYLE_FETCH: cfg_c1_mode <= MBP_C1_FETCH_READ;
			default: cfg_c1_mode <= MBP_C1_READ_STROBE;
		endcase
		for (int i = 0; i < 4; i++) begin
			cfg_pa_func[i] <= lo;
			cfg_pa_func[i + 4] <= hi;
		end
		cfg_pa_open_drain <= od;
		cfg_c2_mode <= c2;
		// A fetch strobe idles high; low would read on every cycle
		generic_level <= (c2 == MBP_C2_FETCH);
		data_on_port_a <= (lo == MBP_PA_DATA_BUS);
		addr_on_port_a <= (lo == MBP_PA_ADDR_IN);
		reset_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
	endtask

	task automatic bus_op(input logic w, input logic f,
		input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		logic [7:0] dec;
		logic [7:0] exp_dec;
		n = 0;
		dec = 8'hff;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_fetch <= f;
		req_addr <= a;
		req_wdata <= d;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
			// Mid-strobe: decoded levels of the transfer itself
			if (n == 3) begin
				dec = {4'h0, bus_read, bus_write, fetch_active,
					block_selected};
			end
		end while (rsp_valid !== 1'b1 && n < 20);
		cmp_byte(8'(n), 8'h05, "answer latency");
		exp_dec = {4'h0, ~w, w, f, a[11:8] == `MBP_SEL_BASE};
		cmp_byte(dec, exp_dec, "decoded strobes");
		q = rsp_rdata;
	endtask

	task automatic wait_cyc();
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic t_styles();
		logic [7:0] v;
		for (int s = 0; s < 4; s++) begin
			v = 8'h3c ^ 8'(s);
			set_cfg(mbp_bus_style_t'(s), MBP_PA_MCU_IO, MBP_PA_MCU_IO,
				4'h0, MBP_C2_GENERIC);
			bus_op(1'b1, 1'b0, 12'h810, v, rd);
			bus_op(1'b0, 1'b0, 12'h810, 8'h00, rd);
			cmp_byte(rd, v, "style readback");
		end
	endtask

	task automatic t_refuse();
		bus_op(1'b1, 1'b0, 12'h810, 8'h5a, rd);
		bus_op(1'b1, 1'b0, 12'h310, 8'h77, rd);
		bus_op(1'b0, 1'b0, 12'h810, 8'h00, rd);
		cmp_byte(rd, 8'h5a, "unselected write");
		bus_op(1'b0, 1'b0, 12'h300, 8'h00, rd);
		cmp_byte(rd, 8'hff, "unselected read");
	endtask

	task automatic t_port_io(input logic [3:0] od, input logic [7:0] oe);
		set_cfg(MBP_STYLE_SPLIT, MBP_PA_MCU_IO, MBP_PA_MCU_IO, od,
			MBP_C2_GENERIC);
		bus_op(1'b0, 1'b0, 12'h810, 8'h00, rd);
		cmp_byte(rd, 8'h00, "direction reset");
		bus_op(1'b0, 1'b0, 12'h800, 8'h00, rd);
		cmp_byte(rd, 8'hff, "inputs float high");
		bus_op(1'b1, 1'b0, 12'h810, 8'hff, rd);
		bus_op(1'b1, 1'b0, 12'h800, 8'ha5, rd);
		bus_op(1'b0, 1'b0, 12'h800, 8'h00, rd);
		cmp_byte(rd, 8'ha5, "port data");
		cmp_byte(bus.port_a_pins, 8'ha5, "pin levels");
		cmp_byte(logic_port_a, 8'ha5, "pins to logic");
		cmp_byte(bus.port_a_dev_oe, oe, "output type");
	endtask

	task automatic t_slew();
		cmp_byte({4'h0, pa_fast_slew}, 8'h05, "slew config");
		@(posedge ref_clk);
		cfg_pa_fast_slew <= 4'ha;
		wait_cyc();
		cmp_byte({4'h0, pa_fast_slew}, 8'h05, "config held");
	endtask

	task automatic t_port_funcs();
		set_cfg(MBP_STYLE_SPLIT, MBP_PA_MACROCELL, MBP_PA_MACROCELL, 4'h0,
			MBP_C2_GENERIC);
		wait_cyc();
		cmp_byte(bus.port_a_pins, 8'h3c, "macrocell out");
		@(posedge ref_clk);
		shared_macrocell_outputs <= 8'hc3;
		wait_cyc();
		cmp_byte(bus.port_a_pins, 8'hc3, "macrocell follow");
		set_cfg(MBP_STYLE_SPLIT, MBP_PA_LOGIC_IN, MBP_PA_LOGIC_IN, 4'h0,
			MBP_C2_GENERIC);
		wait_cyc();
		cmp_byte(bus.port_a_dev_oe, 8'h00, "logic input");
		cmp_byte(logic_port_a, 8'hff, "logic input level");
		set_cfg(MBP_STYLE_SPLIT, MBP_PA_ADDR_IN, MBP_PA_LATCHED_ADDR, 4'h0,
			MBP_C2_GENERIC);
		bus_op(1'b0, 1'b0, 12'h81c, 8'h00, rd);
		cmp_word(logic_addr, 12'h81c, "latched address");
		cmp_byte(bus.port_a_pins, 8'h1f, "address out");
		set_cfg(MBP_STYLE_SPLIT, MBP_PA_DATA_BUS, MBP_PA_DATA_BUS, 4'h0,
			MBP_C2_GENERIC);
		bus_op(1'b1, 1'b0, 12'h810, 8'h96, rd);
		bus_op(1'b0, 1'b0, 12'h810, 8'h00, rd);
		cmp_byte(rd, 8'h96, "port data bus");
	endtask

	task automatic t_ctrl_two();
		set_cfg(MBP_STYLE_SPLIT, MBP_PA_MCU_IO, MBP_PA_MCU_IO, 4'h0,
			MBP_C2_FETCH);
		bus_op(1'b1, 1'b0, 12'h810, 8'h69, rd);
		bus_op(1'b0, 1'b1, 12'h810, 8'h00, rd);
		cmp_byte(rd, 8'h69, "fetch read");
		set_cfg(MBP_STYLE_SPLIT, MBP_PA_MCU_IO, MBP_PA_MCU_IO, 4'h0,
			MBP_C2_GENERIC);
		@(posedge ref_clk);
		generic_level <= 1'b1;
		wait_cyc();
		cmp_byte({5'h00, logic_ctrl}, 8'h07, "ctrl terms high");
		@(posedge ref_clk);
		generic_level <= 1'b0;
		wait_cyc();
		cmp_byte({5'h00, logic_ctrl}, 8'h03, "generic input");
	endtask

	// Whole run is well under a thousand cycles
	initial begin
		#(100 * 5000);
		error_cnt++;
		end_sim();
	end

	initial begin
		error_cnt = 0;
		checks_done = 0;
		reset_n = 1'b0;
		cfg_c0_mode = MBP_C0_WRITE_STROBE;
		cfg_c1_mode = MBP_C1_READ_STROBE;
		cfg_c2_mode = MBP_C2_GENERIC;
		cfg_pa_func = '0;
		cfg_pa_open_drain = 4'h0;
		cfg_pa_fast_slew = 4'h5;
		shared_macrocell_outputs = 8'h3c;
		style = MBP_STYLE_SPLIT;
		data_on_port_a = 1'b0;
		addr_on_port_a = 1'b0;
		generic_level = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_fetch = 1'b0;
		req_addr = 12'h000;
		req_wdata = 8'h00;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_styles();
		t_refuse();
		t_port_io(4'h0, 8'hff);
		t_port_io(4'hf, 8'h5f);
		t_slew();
		t_port_funcs();
		t_ctrl_two();
		end_sim();
	end
endmodule
